// *** src/hw_mon_pkg.sv ***
// constants, types and helper functions shared by the monitor sequencer files
package hw_mon_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_READING = 8'h20;
  localparam logic [7:0] ADDR_RUN_CTRL = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h41;
  localparam logic [7:0] ADDR_LIM_LO = 8'h50;
  localparam logic [7:0] ADDR_LIM_HI = 8'h58;
  localparam logic [7:0] ADDR_SFC = 8'h7c;
  localparam logic [7:0] ADDR_SETUP = 8'h7f;
  localparam logic [6:0] SMB_SLAVE_ADDR = 7'h2e;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int RUN_START_BIT = 0;
  localparam int RUN_LOCK_BIT = 1;
  localparam int SFC_LOW_POWER_BIT = 0;
  localparam int SFC_MODE_BIT = 1;
  localparam int SFC_MEAN_MSB = 7;
  localparam int SFC_MEAN_LSB = 5;
  localparam int SETUP_SOFT_BIT = 7;
  localparam int STAT_FAULT1_BIT = 5;
  localparam int STAT_FAULT2_BIT = 6;
  localparam logic [7:0] SFC_RST = 8'h40;
  localparam logic [6:0] SETUP_RST = 7'h00;
  localparam logic [6:0] STATUS_RST = 7'h00;
  localparam logic [7:0] LIM_LO_RST = 8'h00;
  localparam logic [7:0] LIM_HI_RST = 8'h7f;
  localparam logic [7:0] DIODE_FAULT_VALUE = 8'h80;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_HZ = 125_000_000;
  localparam int CONV_CLK_HZ = 45_000;
  localparam int CONV_TICK_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam logic [15:0] TEMPERATURE_CLKS = 16'h0060;
  localparam logic [15:0] VOLTAGE_CLKS = 16'h0044;
  localparam int IDLE_TIME_MS = 1000;
  localparam int IDLE_TICKS = IDLE_TIME_MS * CONV_CLK_HZ / 1000;

  // ----------------------------------------------------------------------
  // channels in conversion order
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 5;
  localparam logic [2:0] CH_REMOTE1 = 3'h0;
  localparam logic [2:0] CH_AMBIENT = 3'h1;
  localparam logic [2:0] CH_VCC = 3'h2;
  localparam logic [2:0] CH_VCCP = 3'h3;
  localparam logic [2:0] CH_REMOTE2 = 3'h4;

  typedef enum logic [1:0] {
    SEQ_STOP = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_WAIT = 2'b10
  } seq_state_t;

  typedef enum logic [2:0] {
    SMB_IDLE = 3'b000,
    SMB_ADDR = 3'b001,
    SMB_REG = 3'b010,
    SMB_WDATA = 3'b011,
    SMB_ACK = 3'b100,
    SMB_RDATA = 3'b101,
    SMB_IGNORE = 3'b110
  } smb_state_t;

  // remote diode channels
  function automatic logic is_remote(input logic [2:0] ch);
    return (ch == CH_REMOTE1) || (ch == CH_REMOTE2);
  endfunction : is_remote

  // conversion length in conversion clocks
  function automatic logic [15:0] conv_len(input logic [2:0] ch);
    return (is_remote(ch) || ch == CH_AMBIENT) ? TEMPERATURE_CLKS : VOLTAGE_CLKS;
  endfunction : conv_len

  // log2 of samples per reading, highest set select bit wins
  function automatic logic [2:0] mean_shift(input logic [2:0] sel, input logic [2:0] ch);
    if (sel[2]) return 3'h5;
    else if (sel[1]) return 3'h4;
    else if (sel[0]) return is_remote(ch) ? 3'h4 : 3'h0;
    else return is_remote(ch) ? 3'h7 : 3'h3;
  endfunction : mean_shift

endpackage : hw_mon_pkg

// *** src/hw_monitor_sequencer.sv ***
// conversion sequencer, averaging, limit checking and monitor registers
//
// Functional notes
// RULE_01: writing one to the start bit at 0x40 begins monitoring.
// RULE_02: each result goes to its reading register; limit and fault outcomes set status.
// RULE_03: power-up loads defaults everywhere except the reading registers.
// RULE_04: setup bit 7 soft-resets all but reading registers, then clears itself.
// RULE_05: bit 1 of the register at 7Ch picks continuous or cycle mode.
// RULE_06: conversions paced at 45 kHz; temperature 96 clocks, voltage 68 clocks.
// RULE_07: averaging field bits 7:5 decoded with the highest set bit winning.
// RULE_08: sample counts 128/8, 16/1, 16 all, 32 all per field value.
// RULE_09: averaging field resets to 010, sixteen samples for every input.
// RULE_10: a reading is written only after all its samples are taken.
// RULE_11: order is remote one, ambient, supply, processor supply, remote two.
// RULE_12: continuous mode restarts the pass immediately with no idle gap.
// RULE_13: a result violating its limit sets that input's status bit.
// RULE_14: cycle mode converts each input once, then idles about one second.
// RULE_15: in cycle mode a result equal to a limit counts as violation.
// RULE_16: readings readable any time; cycle mode updates them once per pass.
// RULE_17: clearing start stops monitoring; bit 0 picks sleep or shutdown.
// RULE_18: a status bit stays set until read and clears only if cause gone.
// RULE_19: a single-cycle 45 kHz tick counts conversion lengths and idle wait.
// RULE_20: mode bit 0 means continuous, 1 means cycle monitoring.
`timescale 1ns/1ps
module hw_monitor_sequencer
  import hw_mon_pkg::*;
#(
  parameter int TICK_DIV = CONV_TICK_DIV,
  parameter int IDLE_TICKS_P = IDLE_TICKS,
  parameter logic [6:0] SLAVE_ADDR = SMB_SLAVE_ADDR
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic [2:0] ADC_CHAN,
  output logic ADC_BUSY,
  output logic ADC_SAMPLE,
  input wire logic [7:0] ADC_DATA,
  input wire logic ADC_FAULT,
  output logic SLEEP_MODE,
  output logic SHUTDOWN_MODE
);

  reg_bus_if bus ();

  logic clr;
  logic start_q, start_d, lock_q, lock_d, soft_q, soft_d;
  logic [7:0] special_function_control_q, special_function_control_d;
  logic [6:0] device_setup_q, device_setup_d;
  logic [6:0] stat_q, stat_d, cond_q, cond_d, set_vec;
  logic sleep_q, shut_q;
  logic [2:0] averaging_select;
  logic low_power_select, cycle_mode, rd_stat, viol;
  logic [7:0] lim_lo_q [NUM_CH];
  logic [7:0] lim_hi_q [NUM_CH];
  logic [7:0] rdg_q [NUM_CH];
  logic [2:0] rd_idx;

  seq_state_t seq_q, seq_d;
  logic [2:0] ch_q, ch_d, sh;
  logic [15:0] tick_q, tick_d, cnt_q, cnt_d;
  logic [7:0] samp_q, samp_d, res_val;
  logic [14:0] acc_q, acc_d, acc_n;
  logic flt_q, flt_d, flt_n, smp_q, smp_d, busy_q, tick, res_valid;

  // ----------------------------------------------------------------------
  // serial register access
  // ----------------------------------------------------------------------
  smbus_byte_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_smbus (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .sda_oe_n(SDA_OE_N),
    .bus(bus)
  );

  assign SDA_OUT = 1'b0;

  // ----------------------------------------------------------------------
  // control registers and status
  // ----------------------------------------------------------------------
  assign clr = !RST_N || soft_q;  // [RULE_03] [RULE_04]
  assign averaging_select = special_function_control_q[SFC_MEAN_MSB:SFC_MEAN_LSB];
  assign low_power_select = special_function_control_q[SFC_LOW_POWER_BIT];
  assign cycle_mode = special_function_control_q[SFC_MODE_BIT];  // [RULE_05] [RULE_20]
  assign rd_stat = bus.rd && bus.addr == ADDR_STATUS;

  // next values of control, status and condition flags
  always_comb begin
    start_d = start_q;
    lock_d = lock_q;
    soft_d = 1'b0;
    special_function_control_d = special_function_control_q;
    device_setup_d = device_setup_q;
    if (bus.wr) begin
      if (bus.addr == ADDR_RUN_CTRL) begin
        if (!lock_q) begin
          start_d = bus.wdata[RUN_START_BIT];  // [RULE_01] [RULE_17]
          lock_d = bus.wdata[RUN_LOCK_BIT];
        end
      end else if (bus.addr == ADDR_SFC) begin
        special_function_control_d = bus.wdata;
        if (lock_q) begin
          special_function_control_d[SFC_LOW_POWER_BIT] = low_power_select;
        end
      end else if (bus.addr == ADDR_SETUP) begin
        device_setup_d = bus.wdata[6:0];
        soft_d = bus.wdata[SETUP_SOFT_BIT];  // [RULE_04]
      end
    end
    // limit check, equality counts only in cycle mode
    if (cycle_mode) begin
      viol = res_val <= lim_lo_q[ch_q] || res_val >= lim_hi_q[ch_q];  // [RULE_15]
    end else begin
      viol = res_val < lim_lo_q[ch_q] || res_val > lim_hi_q[ch_q];  // [RULE_13]
    end
    set_vec = 7'h00;
    cond_d = cond_q;
    if (res_valid) begin
      set_vec[ch_q] = viol;  // [RULE_02]
      cond_d[ch_q] = viol;
      if (ch_q == CH_REMOTE1) begin
        set_vec[STAT_FAULT1_BIT] = flt_n;
        cond_d[STAT_FAULT1_BIT] = flt_n;
      end else if (ch_q == CH_REMOTE2) begin
        set_vec[STAT_FAULT2_BIT] = flt_n;
        cond_d[STAT_FAULT2_BIT] = flt_n;
      end
    end
    // a read clears only bits whose cause is gone; a new event wins
    stat_d = (stat_q & ~(rd_stat ? ~cond_q : 7'h00)) | set_vec;  // [RULE_18]
  end

  // control and status registers
  always_ff @(posedge SYS_CLK) begin
    if (clr) begin
      start_q <= 1'b0;
      lock_q <= 1'b0;
      special_function_control_q <= SFC_RST;  // [RULE_09]
      device_setup_q <= SETUP_RST;
      stat_q <= STATUS_RST;
      cond_q <= STATUS_RST;
      sleep_q <= 1'b0;
      shut_q <= 1'b0;
    end else begin
      start_q <= start_d;
      lock_q <= lock_q | lock_d;
      special_function_control_q <= special_function_control_d;
      device_setup_q <= device_setup_d;
      stat_q <= stat_d;
      cond_q <= cond_d;
      sleep_q <= !start_d && !special_function_control_d[SFC_LOW_POWER_BIT];  // [RULE_17]
      shut_q <= !start_d && special_function_control_d[SFC_LOW_POWER_BIT];
    end
  end

  // self-clearing soft reset pulse
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= soft_d;
    end
  end

  assign SLEEP_MODE = sleep_q;
  assign SHUTDOWN_MODE = shut_q;

  // per channel limits and readings
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [7:0] A_LO = ADDR_LIM_LO + 8'(i);
    localparam logic [7:0] A_HI = ADDR_LIM_HI + 8'(i);
    logic [7:0] lo_d, hi_d, rdg_d;
    assign lo_d = (bus.wr && bus.addr == A_LO) ? bus.wdata : lim_lo_q[i];
    assign hi_d = (bus.wr && bus.addr == A_HI) ? bus.wdata : lim_hi_q[i];
    assign rdg_d = (res_valid && ch_q == 3'(i)) ? res_val : rdg_q[i];  // [RULE_10] [RULE_16]
    always_ff @(posedge SYS_CLK) begin
      if (clr) begin
        lim_lo_q[i] <= LIM_LO_RST;
        lim_hi_q[i] <= LIM_HI_RST;
      end else begin
        lim_lo_q[i] <= lo_d;
        lim_hi_q[i] <= hi_d;
      end
    end
    // readings keep their value through both resets
    always_ff @(posedge SYS_CLK) begin
      rdg_q[i] <= rdg_d;  // [RULE_03]
    end
  end

  // register read data
  always_comb begin
    rd_idx = 3'h0;
    if (bus.addr == ADDR_RUN_CTRL) begin
      bus.rdata = {5'h00, busy_q, lock_q, start_q};
    end else if (bus.addr == ADDR_STATUS) begin
      bus.rdata = {1'b0, stat_q};
    end else if (bus.addr == ADDR_SFC) begin
      bus.rdata = special_function_control_q;
    end else if (bus.addr == ADDR_SETUP) begin
      bus.rdata = {1'b0, device_setup_q};
    end else if (bus.addr >= ADDR_READING && bus.addr < ADDR_READING + 8'(NUM_CH)) begin
      rd_idx = 3'(bus.addr - ADDR_READING);
      bus.rdata = rdg_q[rd_idx];  // [RULE_16]
    end else if (bus.addr >= ADDR_LIM_LO && bus.addr < ADDR_LIM_LO + 8'(NUM_CH)) begin
      rd_idx = 3'(bus.addr - ADDR_LIM_LO);
      bus.rdata = lim_lo_q[rd_idx];
    end else if (bus.addr >= ADDR_LIM_HI && bus.addr < ADDR_LIM_HI + 8'(NUM_CH)) begin
      rd_idx = 3'(bus.addr - ADDR_LIM_HI);
      bus.rdata = lim_hi_q[rd_idx];
    end else begin
      bus.rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    tick = tick_q == 16'h0000;
    tick_d = tick ? 16'(TICK_DIV - 1) : tick_q - 16'h0001;  // [RULE_19]
    seq_d = seq_q;
    ch_d = ch_q;
    cnt_d = cnt_q;
    samp_d = samp_q;
    acc_d = acc_q;
    flt_d = flt_q;
    smp_d = 1'b0;
    res_valid = 1'b0;
    acc_n = acc_q + {7'h00, ADC_DATA};
    flt_n = is_remote(ch_q) && (flt_q || ADC_FAULT);
    sh = mean_shift(averaging_select, ch_q);  // [RULE_07] [RULE_08]
    res_val = flt_n ? DIODE_FAULT_VALUE : 8'(acc_n >> sh);
    case (seq_q)
      SEQ_STOP: begin
        if (start_q) begin
          seq_d = SEQ_CONV;  // [RULE_01]
          ch_d = CH_REMOTE1;
          cnt_d = conv_len(CH_REMOTE1);
          samp_d = 8'h00;
          acc_d = 15'h0000;
          flt_d = 1'b0;
        end
      end
      SEQ_CONV: begin
        if (!start_q) begin
          seq_d = SEQ_STOP;  // [RULE_17]
        end else if (tick) begin
          if (cnt_q != 16'h0001) begin
            cnt_d = cnt_q - 16'h0001;  // [RULE_06]
          end else begin
            smp_d = 1'b1;
            samp_d = samp_q + 8'h01;
            acc_d = acc_n;
            flt_d = flt_n;
            cnt_d = conv_len(ch_q);
            if (samp_q == 8'((16'h0001 << sh) - 16'h0001)) begin
              res_valid = 1'b1;  // [RULE_10]
              samp_d = 8'h00;
              acc_d = 15'h0000;
              flt_d = 1'b0;
              if (ch_q == CH_REMOTE2) begin
                ch_d = CH_REMOTE1;
                cnt_d = conv_len(CH_REMOTE1);
                if (cycle_mode) begin
                  seq_d = SEQ_WAIT;  // [RULE_14]
                  cnt_d = 16'(IDLE_TICKS_P);
                end
              end else begin
                ch_d = ch_q + 3'h1;  // [RULE_11] [RULE_12]
                cnt_d = conv_len(ch_q + 3'h1);
              end
            end
          end
        end
      end
      SEQ_WAIT: begin
        if (!start_q) begin
          seq_d = SEQ_STOP;
        end else if (tick) begin
          if (cnt_q != 16'h0001) begin
            cnt_d = cnt_q - 16'h0001;
          end else begin
            seq_d = SEQ_CONV;
            cnt_d = conv_len(CH_REMOTE1);
          end
        end
      end
      default: begin
        seq_d = SEQ_STOP;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge SYS_CLK) begin
    if (clr) begin
      seq_q <= SEQ_STOP;
      ch_q <= CH_REMOTE1;
      cnt_q <= 16'h0000;
      samp_q <= 8'h00;
      acc_q <= 15'h0000;
      flt_q <= 1'b0;
      smp_q <= 1'b0;
      busy_q <= 1'b0;
      tick_q <= 16'h0000;
    end else begin
      seq_q <= seq_d;
      ch_q <= ch_d;
      cnt_q <= cnt_d;
      samp_q <= samp_d;
      acc_q <= acc_d;
      flt_q <= flt_d;
      smp_q <= smp_d;
      busy_q <= seq_d == SEQ_CONV;
      tick_q <= tick_d;
    end
  end

  assign ADC_CHAN = ch_q;
  assign ADC_BUSY = busy_q;
  assign ADC_SAMPLE = smp_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  property p_start;
    seq_q == SEQ_STOP && start_q && !soft_q |=> seq_q == SEQ_CONV && ch_q == CH_REMOTE1;
  endproperty
  a_start: assert property (p_start) else $error("start did not begin a pass"); // [RULE_01]

  property p_soft;
    soft_q |=> !start_q && !lock_q && stat_q == STATUS_RST && device_setup_q == SETUP_RST;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left state behind"); // [RULE_04]

  property p_mean_default;
    $rose(soft_q) |=> averaging_select == 3'h2 ##1 averaging_select == 3'h2;
  endproperty
  a_mean_default: assert property (p_mean_default) else $error("bad averaging default"); // [RULE_09]

  property p_order;
    seq_q == SEQ_CONV && $past(seq_q) == SEQ_CONV && ch_q != $past(ch_q)
      |-> ch_q == 3'($past(ch_q) + 3'h1) || ($past(ch_q) == CH_REMOTE2 && ch_q == CH_REMOTE1);
  endproperty
  a_order: assert property (p_order) else $error("channel order broken"); // [RULE_11]

  property p_no_gap;
    res_valid && ch_q == CH_REMOTE2 && !cycle_mode && !soft_q
      |=> seq_q == SEQ_CONV && ch_q == CH_REMOTE1;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap in continuous mode"); // [RULE_12]

  property p_idle;
    res_valid && ch_q == CH_REMOTE2 && cycle_mode && !soft_q
      |=> seq_q == SEQ_WAIT && cnt_q == 16'(IDLE_TICKS_P) && !ADC_BUSY;
  endproperty
  a_idle: assert property (p_idle) else $error("cycle mode did not idle"); // [RULE_14]

  property p_equal;
    res_valid && cycle_mode && !soft_q && res_val == lim_hi_q[ch_q] |=> stat_q[$past(ch_q)];
  endproperty
  a_equal: assert property (p_equal) else $error("equal value not flagged"); // [RULE_15]

  property p_stop;
    !start_q && !soft_q |=> seq_q == SEQ_STOP && !ADC_BUSY;
  endproperty
  a_stop: assert property (p_stop) else $error("monitoring kept running"); // [RULE_17]

  property p_hold;
    !rd_stat && !soft_q |=> (stat_q & $past(stat_q)) == $past(stat_q);
  endproperty
  a_hold: assert property (p_hold) else $error("status bit dropped unread"); // [RULE_18]

endmodule : hw_monitor_sequencer

// *** src/reg_bus_if.sv ***
// register access strobes between the serial slave and the register file
`timescale 1ns/1ps
interface reg_bus_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport smbus_end (output wr, output rd, output addr, output wdata, input rdata);
  modport regs_end (input wr, input rd, input addr, input wdata, output rdata);
endinterface : reg_bus_if

// *** src/smbus_byte_slave.sv ***
// serial write byte / read byte slave that drives the register strobes
`timescale 1ns/1ps
module smbus_byte_slave
  import hw_mon_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SMB_SLAVE_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  reg_bus_if.smbus_end bus
);

  smb_state_t state_q, state_d, nxt_q, nxt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, addr_q, addr_d, wdata_q, wdata_d;
  logic scl_q, sda_q, oe_n_q, oe_n_d, reg_ok_q, reg_ok_d, wr_q, wr_d, rd_q, rd_d;
  logic rise, fall, start, stop;
  logic [7:0] byte_in;

  // ----------------------------------------------------------------------
  // line events and byte state machine
  // ----------------------------------------------------------------------
  always_comb begin
    rise = scl_in && !scl_q;
    fall = !scl_in && scl_q;
    start = scl_in && scl_q && sda_q && !sda_in;
    stop = scl_in && scl_q && !sda_q && sda_in;
    byte_in = {sh_q[6:0], sda_in};
    state_d = state_q;
    nxt_d = nxt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    oe_n_d = oe_n_q;
    reg_ok_d = reg_ok_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    if (start) begin
      state_d = SMB_ADDR;
      bit_d = 3'h0;
      oe_n_d = 1'b1;
    end else if (stop) begin
      state_d = SMB_IDLE;
      oe_n_d = 1'b1;
      reg_ok_d = 1'b0;
    end else begin
      case (state_q)
        SMB_ADDR, SMB_REG, SMB_WDATA: begin
          if (rise) begin
            sh_d = byte_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_d = SMB_ACK;
              if (state_q == SMB_ADDR) begin
                if (byte_in[7:1] != SLAVE_ADDR || (byte_in[0] && !reg_ok_q)) begin
                  state_d = SMB_IGNORE;
                end else if (byte_in[0]) begin
                  nxt_d = SMB_RDATA;
                  sh_d = bus.rdata;
                  rd_d = 1'b1;
                end else begin
                  nxt_d = SMB_REG;
                end
              end else if (state_q == SMB_REG) begin
                addr_d = byte_in;
                reg_ok_d = 1'b1;
                nxt_d = SMB_WDATA;
              end else begin
                wdata_d = byte_in;
                wr_d = 1'b1;
                reg_ok_d = 1'b0;
                nxt_d = SMB_IGNORE;
              end
            end
          end
        end
        SMB_ACK: begin
          if (fall) begin
            if (oe_n_q) begin
              oe_n_d = 1'b0;
            end else begin
              state_d = nxt_q;
              bit_d = 3'h0;
              oe_n_d = (nxt_q == SMB_RDATA) ? sh_q[7] : 1'b1;
              sh_d = {sh_q[6:0], 1'b0};
            end
          end
        end
        SMB_RDATA: begin
          if (fall) begin
            bit_d = bit_q + 3'h1;
            oe_n_d = (bit_q == 3'h7) ? 1'b1 : sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
            if (bit_q == 3'h7) begin
              state_d = SMB_IGNORE;
            end
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= SMB_IDLE;
      nxt_q <= SMB_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      oe_n_q <= 1'b1;
      reg_ok_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      nxt_q <= nxt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      scl_q <= scl_in;
      sda_q <= sda_in;
      oe_n_q <= oe_n_d;
      reg_ok_q <= reg_ok_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // register strobes and pin drive
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign sda_oe_n = oe_n_q;

endmodule : smbus_byte_slave

// *** tb/adc_model.sv ***
// converter front end model
`timescale 1ns/1ps
module adc_model (
  input wire logic clk,
  input wire logic [2:0] chan,
  input wire logic busy,
  input wire logic [7:0] lvl,
  output logic [7:0] data
);
  // ----
  // level per channel, scrambled while idle
  // ----
  always_ff @(posedge clk) begin
    data <= busy ? lvl + {5'h0, chan} : ~data;
  end
endmodule : adc_model

// *** tb/hw_monitor_sequencer_tb.sv ***
// self-checking bench for the monitor sequencer
`timescale 1ns/1ps
module hw_monitor_sequencer_tb;
  import hw_mon_pkg::*;
  // ----
  // signals and instances
  // ----
  logic clk = 0, rst_n = 0, scl = 1, sda_h = 1, run = 0, flt = 0;
  logic oe_n, sda_o, busy, smp, slp, shd;
  logic [2:0] ch, pch, lc = 0;
  logic [7:0] lvl, adc, rd, sfc = SFC_RST;
  logic [31:0] rs = 32'h9739c4d0;
  int error_cnt = 0, tests_run = 0, cnt = 0, idle = 0, passes = 0;
  wire sda = sda_h & (oe_n | sda_o);
  always #4 clk = ~clk;
  hw_monitor_sequencer #(.TICK_DIV(2), .IDLE_TICKS_P(10)) hw_monitor_sequencer_i (
    .SYS_CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE_N(oe_n), .ADC_CHAN(ch), .ADC_BUSY(busy), .ADC_SAMPLE(smp),
    .ADC_DATA(adc), .ADC_FAULT(flt), .SLEEP_MODE(slp), .SHUTDOWN_MODE(shd));
  adc_model adc_model_i (.clk(clk), .chan(ch), .busy(busy), .lvl(lvl), .data(adc));
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  // samples per reading by averaging field, r for remote inputs
  function automatic int nexp(input logic [2:0] s, input logic r);
    return s[2] ? 32 : s[1] ? 16 : s[0] ? (r ? 16 : 1) : (r ? 128 : 8);
  endfunction : nexp
  // serial bus: one line phase of four clocks
  task automatic ln(input logic c, input logic d);
    scl = c;
    sda_h = d;
    repeat (4) @(posedge clk);
    #1;
  endtask : ln
  task automatic sb(input logic [7:0] v, output logic [7:0] r);
    for (int i = 8; i >= 0; i--) begin
      ln(0, i ? v[i-1] : 1'b1);
      ln(1, i ? v[i-1] : 1'b1);
      if (i) r[i-1] = sda;
      ln(0, i ? v[i-1] : 1'b1);
    end
  endtask : sb
  task automatic st;
    ln(0, 1);
    ln(1, 1);
    ln(1, 0);
    ln(0, 0);
  endtask : st
  task automatic sp;
    ln(0, 0);
    ln(1, 0);
    ln(1, 1);
  endtask : sp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    st;
    sb({SMB_SLAVE_ADDR, 1'b0}, rd);
    sb(a, rd);
    sb(d, rd);
    sp;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    st;
    sb({SMB_SLAVE_ADDR, 1'b0}, rd);
    sb(a, rd);
    st;
    sb({SMB_SLAVE_ADDR, 1'b1}, rd);
    sb(8'hff, rd);
    sp;
    chk(rd, e);
  endtask : rc
  // random level, one limit on channel c set o below it, run two passes
  task automatic go(input logic [7:0] s, input logic [7:0] c, input logic [7:0] o);
    int p;
    rs = xs(rs);
    lvl = {3'h1, rs[4:0]};
    sfc = s;
    wr(ADDR_SFC, s);
    wr(ADDR_LIM_HI + c, lvl + c - o);
    cnt = 0;
    lc = 0;
    p = passes;
    wr(ADDR_RUN_CTRL, 8'h01);
    chk(busy, 1'b1);
    run = 1;
    for (int k = 0; k < 60000 && passes < p + 2; k++) @(posedge clk);
    #1;
    chk(passes >= p + 2, 1'b1);
    rc(ADDR_READING + c, lvl + c);
    run = 0;
  endtask : go
  // sample count per channel, order and idle gap
  always @(posedge clk) begin
    pch <= ch;
    idle <= busy ? 0 : idle + 1;
    if (run && !sfc[1] && !busy) chk(busy, 1'b1);
    if (busy && idle > 0 && lc == 3'h4) chk(idle >= 19 && idle <= 23, 1'b1);
    if (smp && pch != lc) begin
      chk(cnt, nexp(sfc[7:5], lc == 3'h0 || lc == 3'h4));
      chk(pch, lc == 3'h4 ? 3'h0 : lc + 3'h1);
      passes <= passes + (pch == 3'h0);
      cnt <= 1;
    end else if (smp) cnt <= cnt + 1;
    if (smp) lc <= pch;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    ln(1, 1);
    chk(slp, 1'b1);
    rc(ADDR_SFC, SFC_RST);
    rc(ADDR_LIM_HI + 8'h2, LIM_HI_RST);
    rc(8'h10, 8'h00);
    go(8'h20, 8'h2, 8'h1);
    rc(ADDR_STATUS, 8'h04);
    rc(ADDR_STATUS, 8'h04);
    // cause removed: the bit stays until the next read, which then clears it
    wr(ADDR_LIM_HI + 8'h2, LIM_HI_RST);
    repeat (7000) @(posedge clk);
    #1;
    rc(ADDR_STATUS, 8'h04);
    rc(ADDR_STATUS, 8'h00);
    $display("test continuous done");
    wr(ADDR_RUN_CTRL, 8'h00);
    chk(busy, 1'b0);
    wr(ADDR_SETUP, 8'h80);
    rc(ADDR_SFC, SFC_RST);
    rc(ADDR_STATUS, 8'h00);
    rc(ADDR_SETUP, 8'h00);
    rc(ADDR_READING + 8'h4, lvl + 8'h4);
    $display("test soft reset done");
    // diode fault on both remote inputs throughout the cycle test
    flt = 1;
    go(8'h62, 8'h3, 8'h0);
    rc(ADDR_STATUS, 8'h79);
    rc(ADDR_READING, DIODE_FAULT_VALUE);
    wr(ADDR_RUN_CTRL, 8'h00);
    wr(ADDR_SFC, 8'h43);
    chk(shd, 1'b1);
    $display("test cycle done");
    final_report;
  end
  // watchdog
  initial begin
    #800us;
    error_cnt++;
    final_report;
  end
endmodule : hw_monitor_sequencer_tb
